// File: asi_pkg.sv
// Package with register map, field layout and reset values of the idle and status bank
`default_nettype none
package asi_pkg;
    // Register addresses on the management port
    localparam logic [7:0] ASI_ADDR_IDLE_LOW = 8'h0D;
    localparam logic [7:0] ASI_ADDR_IDLE_HIGH = 8'h0E;
    localparam logic [7:0] ASI_ADDR_STATE_INFO = 8'h1D;
    // Reset values of the idle character pair (K28.5 control symbol)
    localparam logic [7:0] ASI_IDLE_LOW_RST = 8'h83;
    localparam logic [1:0] ASI_IDLE_HIGH_RST = 2'h2;
    // Field positions in the idle high register
    localparam int ASI_IDLE_HIGH_LSB = 0;
    localparam int ASI_IDLE_HIGH_MSB = 1;
    // Field positions in the state info register
    localparam int ASI_STATE_LOOP_BIT = 5;
    localparam int ASI_STATE_MODE_LSB = 3;
    localparam int ASI_STATE_MODE_MSB = 4;
    localparam int ASI_STATE_VAR_LSB = 6;
    localparam int ASI_STATE_VAR_MSB = 7;
    // Operating mode code that means serial interface mode
    localparam logic [1:0] ASI_MODE_SERIAL = 2'h3;
    // Word and FIFO geometry
    localparam int ASI_WORD_W = 10;
    localparam int ASI_FIFO_DEPTH = 16;
    // Output stream sources
    typedef enum {
        ASI_SRC_DATA,
        ASI_SRC_IDLE
    } asi_src_t;
endpackage
`default_nettype wire

// File: asi_fifo.sv
// Word FIFO with registered head stage, valid and ready on both sides
`default_nettype none
module asi_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, next_wr_ptr;
    logic [AW-1:0] rd_ptr, next_rd_ptr;
    logic [CW-1:0] count, next_count;
    logic [WIDTH-1:0] head, next_head;
    logic head_valid, next_head_valid;
    logic push, pop;
    logic in_ready, next_in_ready;

    // Room flag is a flop of the count after this edge, so it is never a cycle late
    assign in_ready_out = in_ready;
    assign out_data_out = head;
    assign out_valid_out = head_valid;

    // Head refills whenever it is empty or being taken; honest empty via head_valid
    always_comb begin
        push = in_valid_in && (count != FULL_CNT);
        pop = (count != '0) && (!head_valid || out_ready_in);
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
        next_in_ready = (next_count != FULL_CNT);
        next_head = head;
        next_head_valid = head_valid;
        if (pop) begin
            next_head = mem[rd_ptr];
            next_head_valid = 1'b1;
        end else if (out_ready_in) begin
            next_head_valid = 1'b0;
        end
    end

    // Pointer and head registers
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            head <= '0;
            head_valid <= 1'b0;
            in_ready <= 1'b0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            head <= next_head;
            head_valid <= next_head_valid;
            in_ready <= next_in_ready;
        end
    end

    // Storage needs no reset; nothing reads a slot before it is written
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end
endmodule // asi_fifo
`default_nettype wire

// File: asi_regs.sv
// Idle character and state info registers with idle insertion on the word stream
//
// Summary of operation
// - Output idle character on each ready edge without valid data; reset word is zero
// - Idle resets to K28.5, split low/high pair
// - Bit 5 shows loop-through, resets to 0, then taken from pin on first edge after reset
// - Bits 4:3 mode: 11 serial, else video
// - State read returns 8 bits with variant
`default_nettype none
module asi_regs
    import asi_pkg::*;
#(
    parameter int WORD_W = ASI_WORD_W,
    parameter int FIFO_DEPTH = ASI_FIFO_DEPTH,
    parameter logic [1:0] VARIANT = 2'h0 // Arbitrary value
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    // Received word stream
    input wire logic [WORD_W-1:0] rx_word_in,
    input wire logic rx_valid_in,
    output logic rx_ready_out,
    // Outgoing word stream
    output logic [WORD_W-1:0] out_word_out,
    output logic out_idle_out,
    input wire logic out_ready_in,
    // Status sources
    input wire logic loop_en_pin_in,
    input wire logic [1:0] mode_in,
    output logic loop_en_out,
    output logic serial_mode_out,
    // Management register port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out
);
    logic [WORD_W-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_in_ready;

    logic [7:0] idle_char_low, next_idle_char_low;
    logic [1:0] idle_char_high, next_idle_char_high;
    logic loop_en, next_loop_en;
    logic strap_taken, next_strap_taken;
    logic [1:0] mode, next_mode;
    logic [7:0] rdata, next_rdata;
    logic rvalid, next_rvalid;
    logic [WORD_W-1:0] out_word, next_out_word;
    logic out_idle, next_out_idle;
    logic serial_mode, next_serial_mode;
    logic [7:0] state_info;
    logic [9:0] idle_char;
    asi_src_t src;

    // Buffer between receiver and output; its ready stalls the receiver
    asi_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .in_data_in(rx_word_in),
        .in_valid_in(rx_valid_in && fifo_in_ready),
        .in_ready_out(fifo_in_ready),
        .out_data_out(fifo_data),
        .out_valid_out(fifo_valid),
        .out_ready_in(out_ready_in)
    );

    assign idle_char = {idle_char_high, idle_char_low};

    // State info word; unused bits read zero
    always_comb begin
        state_info = 8'h00;
        state_info[ASI_STATE_VAR_MSB:ASI_STATE_VAR_LSB] = VARIANT;
        state_info[ASI_STATE_LOOP_BIT] = loop_en;
        state_info[ASI_STATE_MODE_MSB:ASI_STATE_MODE_LSB] = mode;
    end

    // Register writes, strap capture, status tracking and read answer
    always_comb begin
        next_idle_char_low = idle_char_low;
        next_idle_char_high = idle_char_high;
        next_loop_en = loop_en;
        next_strap_taken = 1'b1;
        next_mode = mode_in;
        next_serial_mode = (mode_in == ASI_MODE_SERIAL);
        next_rdata = rdata;
        next_rvalid = reg_rd_in;
        // Pin is caught on the first edge after release, never under reset
        if (!strap_taken) begin
            next_loop_en = loop_en_pin_in;
        end
        if (reg_wr_in) begin
            case (reg_addr_in)
                ASI_ADDR_IDLE_LOW: begin
                    next_idle_char_low = reg_wdata_in;
                end
                ASI_ADDR_IDLE_HIGH: begin
                    next_idle_char_high =
                        reg_wdata_in[ASI_IDLE_HIGH_MSB:ASI_IDLE_HIGH_LSB];
                end
                default: begin
                    next_idle_char_low = idle_char_low; // State info is read only
                end
            endcase
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                ASI_ADDR_IDLE_LOW: next_rdata = idle_char_low;
                ASI_ADDR_IDLE_HIGH: next_rdata = {6'h00, idle_char_high};
                ASI_ADDR_STATE_INFO: next_rdata = state_info;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Register state
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            idle_char_low <= ASI_IDLE_LOW_RST;
            idle_char_high <= ASI_IDLE_HIGH_RST;
            loop_en <= 1'b0;
            strap_taken <= 1'b0;
            mode <= 2'h0;
            serial_mode <= 1'b0;
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            idle_char_low <= next_idle_char_low;
            idle_char_high <= next_idle_char_high;
            loop_en <= next_loop_en;
            strap_taken <= next_strap_taken;
            mode <= next_mode;
            serial_mode <= next_serial_mode;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // Output word: buffered data when present, idle character otherwise
    always_comb begin
        src = fifo_valid ? ASI_SRC_DATA : ASI_SRC_IDLE;
        next_out_word = out_word;
        next_out_idle = out_idle;
        if (out_ready_in) begin
            case (src)
                ASI_SRC_DATA: begin
                    next_out_word = fifo_data;
                    next_out_idle = 1'b0;
                end
                ASI_SRC_IDLE: begin
                    next_out_word = WORD_W'(idle_char);
                    next_out_idle = 1'b1;
                end
                default: begin
                    next_out_word = WORD_W'(idle_char);
                    next_out_idle = 1'b1;
                end
            endcase
        end
    end

    // Output stage; receiver ready comes from the FIFO's own room flop,
    // which looks one edge ahead so no accepted word is ever dropped
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            out_word <= '0;
            out_idle <= 1'b1;
        end else begin
            out_word <= next_out_word;
            out_idle <= next_out_idle;
        end
    end

    assign out_word_out = out_word;
    assign out_idle_out = out_idle;
    assign rx_ready_out = fifo_in_ready;
    assign loop_en_out = loop_en;
    assign serial_mode_out = serial_mode;
    assign reg_rdata_out = rdata;
    assign reg_rvalid_out = rvalid;
endmodule // asi_regs
`default_nettype wire

// File: asi_regs_sva.sv
// Assertion checker for the idle and status register bank
`default_nettype none
module asi_regs_chk
    import asi_pkg::*;
#(
    parameter int WORD_W = ASI_WORD_W,
    parameter logic [1:0] VARIANT = 2'h0
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [WORD_W-1:0] out_word_out,
    input wire logic out_idle_out,
    input wire logic out_ready_in,
    input wire logic [1:0] mode_in,
    input wire logic loop_en_out,
    input wire logic serial_mode_out,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_rvalid_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    logic rd_st;
    logic rd_hi;
    logic rd_un;
    // Reads sorted by target; unmapped covers all other addresses
    assign rd_st = reg_rd_in && reg_addr_in == ASI_ADDR_STATE_INFO;
    assign rd_hi = reg_rd_in && reg_addr_in == ASI_ADDR_IDLE_HIGH;
    assign rd_un = reg_rd_in && !(rd_st || rd_hi || reg_addr_in == ASI_ADDR_IDLE_LOW);
    property p_ans; reg_rd_in |=> reg_rvalid_out; endproperty
    a_ans: assert property (p_ans) else $error("read not answered");
    property p_quiet; !reg_rd_in |=> !reg_rvalid_out; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without read");
    property p_stat;
        rd_st |=> reg_rdata_out[7:5] == {VARIANT, $past(loop_en_out)}
            && reg_rdata_out[2:0] == 3'h0;
    endproperty
    a_stat: assert property (p_stat) else $error("state info bits wrong");
    property p_mode; rd_st |=> (reg_rdata_out[4:3] == ASI_MODE_SERIAL) == $past(serial_mode_out);
    endproperty
    a_mode: assert property (p_mode) else $error("mode field wrong");
    property p_hi; rd_hi |=> reg_rdata_out[7:2] == 6'h00; endproperty
    a_hi: assert property (p_hi) else $error("idle high spare bits set");
    property p_un; rd_un |=> reg_rdata_out == 8'h00; endproperty
    a_un: assert property (p_un) else $error("unmapped read not zero");
    property p_ser; $past(nrst_in) |-> serial_mode_out == ($past(mode_in) == ASI_MODE_SERIAL);
    endproperty
    a_ser: assert property (p_ser) else $error("serial mode flag wrong");
    property p_loop; $past(nrst_in, 2) |-> $stable(loop_en_out); endproperty
    a_loop: assert property (p_loop) else $error("loop enable moved");
    property p_hold; !out_ready_in |=> $stable(out_word_out) && $stable(out_idle_out); endproperty
    a_hold: assert property (p_hold) else $error("output moved in stall");
    c_rd: cover property (rd_st ##1 reg_rvalid_out);
    c_ser: cover property (serial_mode_out);
    c_data: cover property (out_ready_in && !out_idle_out);
endmodule // asi_regs_chk

bind asi_regs asi_regs_chk #(.WORD_W(WORD_W), .VARIANT(VARIANT)) chk (
    .clk_in(clk_in), .nrst_in(nrst_in), .out_word_out(out_word_out),
    .out_idle_out(out_idle_out), .out_ready_in(out_ready_in), .mode_in(mode_in),
    .loop_en_out(loop_en_out), .serial_mode_out(serial_mode_out),
    .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out));
`default_nettype wire

// File: asi_sink.sv
// Word stream consumer model that stalls on request and logs data words
`default_nettype none
module asi_sink
    import asi_pkg::*;
(
    input wire logic clk_in,
    input wire logic stall_in,
    input wire logic [ASI_WORD_W-1:0] word_in,
    input wire logic idle_in,
    output logic ready_out
);
    logic [ASI_WORD_W-1:0] got[$];
    logic stall_q = 1'h1;
    logic took = 1'h0;
    assign ready_out = !stall_q;
    // Ready moves at the falling edge, away from the sampling edge
    always @(negedge clk_in) begin
        if (took && !idle_in) got.push_back(word_in);
        stall_q <= stall_in;
    end
    // Remember whether the last rising edge consumed a word
    always @(posedge clk_in) took <= ready_out;
endmodule // asi_sink
`default_nettype wire

// File: asi_regs_test.sv
// Self-checking bench for the idle and status register bank
`default_nettype none
module asi_regs_test;
    timeunit 1ns;
    timeprecision 100ps;
    import asi_pkg::*;
    localparam logic [1:0] VAR = 2'h1; // Arbitrary value
    logic clk_in = 1'h0, nrst_in = 1'h0, rx_valid_in = 1'h0, loop_en_pin_in = 1'h0;
    logic reg_wr_in = 1'h0, reg_rd_in = 1'h0, stall = 1'h1;
    logic [9:0] rx_word_in = 10'h000;
    logic [1:0] mode_in = 2'h0;
    logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
    wire logic rx_ready_out, out_idle_out, out_ready_in, loop_en_out, serial_mode_out;
    wire logic reg_rvalid_out;
    wire logic [9:0] out_word_out;
    wire logic [7:0] reg_rdata_out;
    int fail_count = 0, checked = 0, cyc = 0;
    asi_regs #(.VARIANT(VAR)) uut (.clk_in(clk_in), .nrst_in(nrst_in),
        .rx_word_in(rx_word_in), .rx_valid_in(rx_valid_in), .rx_ready_out(rx_ready_out),
        .out_word_out(out_word_out), .out_idle_out(out_idle_out),
        .out_ready_in(out_ready_in), .loop_en_pin_in(loop_en_pin_in), .mode_in(mode_in),
        .loop_en_out(loop_en_out), .serial_mode_out(serial_mode_out),
        .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out));
    asi_sink host (.clk_in(clk_in), .stall_in(stall), .word_in(out_word_out),
        .idle_in(out_idle_out), .ready_out(out_ready_in));
    initial forever #2.5 clk_in = ~clk_in;
    // Hang guard, far above the fewer than 150 cycles needed
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic final_report();
        if (fail_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk10(input logic [9:0] got, input logic [9:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic do_reset(input logic pin);
        nrst_in = 1'h0;
        loop_en_pin_in = pin;
        repeat (12) @(negedge clk_in);
        nrst_in = 1'h1;
        repeat (2) @(negedge clk_in);
    endtask
    // Strobes drop a cycle before the next request may rise
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'h1;
        @(negedge clk_in);
        reg_wr_in = 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_rd_in = 1'h1;
        @(negedge clk_in);
        reg_rd_in = 1'h0;
        chk8({7'h00, reg_rvalid_out}, 8'h01);
        chk8(reg_rdata_out, exp);
    endtask
    // Reset values, access kinds, refused places, idle insertion
    task automatic t_regs();
        rd(ASI_ADDR_IDLE_LOW, 8'h83);
        rd(ASI_ADDR_IDLE_HIGH, 8'h02);
        stall = 1'h0;
        repeat (4) @(negedge clk_in);
        chk10(out_word_out, 10'h283);
        chk8({7'h00, out_idle_out}, 8'h01);
        wr(ASI_ADDR_IDLE_HIGH, 8'hFF);
        rd(ASI_ADDR_IDLE_HIGH, 8'h03);
        wr(ASI_ADDR_STATE_INFO, 8'hFF);
        rd(ASI_ADDR_STATE_INFO, {VAR, 1'h1, 2'h0, 3'h0});
        rd(8'h40, 8'h00);
        wr(ASI_ADDR_IDLE_LOW, 8'h7C);
        wr(ASI_ADDR_IDLE_HIGH, 8'h01);
        repeat (2) @(negedge clk_in);
        chk10(out_word_out, 10'h17C);
    endtask
    // Every mode code, with loop enable and variant beside it
    task automatic t_status(input logic pin);
        for (int m = 0; m < 4; m++) begin
            mode_in = m[1:0];
            rd(ASI_ADDR_STATE_INFO, {VAR, pin, m[1:0], 3'h0});
            chk8({7'h00, serial_mode_out}, {7'h00, m == 3});
            chk8({7'h00, loop_en_out}, {7'h00, pin});
        end
    endtask
    // Fill the buffer against a stalled consumer, then drain in order
    task automatic t_fifo();
        int n;
        stall = 1'h1;
        @(negedge clk_in);
        host.got.delete();
        for (n = 0; n < 40 && rx_ready_out === 1'h1; n++) begin
            rx_word_in = 10'h100 + n[9:0];
            rx_valid_in = 1'h1;
            @(negedge clk_in);
        end
        rx_valid_in = 1'h0;
        stall = 1'h0;
        repeat (40) @(negedge clk_in);
        chk8({7'h00, host.got.size() >= 16}, 8'h01);
        chk8(host.got.size(), n);
        foreach (host.got[i]) chk10(host.got[i], 10'h100 + i[9:0]);
        chk8({7'h00, out_idle_out}, 8'h01);
    endtask
    initial begin
        do_reset(1'h1);
        t_regs();
        t_status(1'h1);
        t_fifo();
        do_reset(1'h0);
        t_status(1'h0);
        final_report();
    end
endmodule // asi_regs_test
`default_nettype wire
